// file: fgr_pkg.sv
// Functional notes
// - Voltage sample 10 ms after reset initialises charge
// - AA55 at 0x04 initialises from peak voltage
// - AA55 at 0x07 initialises from present voltage
// - Temperature in 0.1 K, 0x09E4 to 0x0D04
// - Thermistor mode powers and senses thermistor itself
// - Cell voltage reported in 1 mV units
// - Charge mode never falls, discharge never rises, except the first estimate after an initialisation
// - Charge percent in 1% steps, 0 to 100
// - Charge permille 0.1% steps, 0 to 1000
// - Profile select 0 or 1 chooses profile
// - Read-only profile set id and chip version
// - Low charge below threshold drives alarm low
// - Low voltage below threshold drives alarm low
// - Power mode 2 sleeps, 1 operational
// - Sleep freezes estimate, resume from held data
// - Direction codes auto 0, charge 1, discharge FFFF
// - Profile write performs full initialisation
// - Writes without valid CRC-8 are discarded
package fgr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [7:0] OFS_INIT_PEAK = 8'h04;
  localparam logic [7:0] OFS_BETA = 8'h06;
  localparam logic [7:0] OFS_INIT_PRESENT = 8'h07;
  localparam logic [7:0] OFS_TEMP = 8'h08;
  localparam logic [7:0] OFS_VOLT = 8'h09;
  localparam logic [7:0] OFS_DIR = 8'h0A;
  localparam logic [7:0] OFS_IMPEDANCE = 8'h0B;
  localparam logic [7:0] OFS_THERM_DELAY = 8'h0C;
  localparam logic [7:0] OFS_PERCENT = 8'h0D;
  localparam logic [7:0] OFS_PERMILLE = 8'h0F;
  localparam logic [7:0] OFS_VERSION = 8'h11;
  localparam logic [7:0] OFS_PROFILE = 8'h12;
  localparam logic [7:0] OFS_ALARM_CHG = 8'h13;
  localparam logic [7:0] OFS_ALARM_VOLT = 8'h14;
  localparam logic [7:0] OFS_PWR = 8'h15;
  localparam logic [7:0] OFS_TSRC = 8'h16;
  localparam logic [7:0] OFS_PROFILE_ID = 8'h1A;

  ////////////////////////////////////////////////////////////////////////////////
  // Codes, ranges and values after reset.
  localparam logic [15:0] INIT_KEY = 16'hAA55;
  localparam logic [15:0] DIR_AUTO = 16'h0000;
  localparam logic [15:0] DIR_CHARGE = 16'h0001;
  localparam logic [15:0] DIR_DISCHARGE = 16'hFFFF;
  localparam logic [15:0] PWR_OPERATIONAL = 16'h0001;
  localparam logic [15:0] PWR_SLEEP = 16'h0002;
  localparam logic [15:0] TSRC_HOST = 16'h0000;
  localparam logic [15:0] TSRC_THERMISTOR = 16'h0001;
  localparam logic [15:0] PROFILE_MAX = 16'h0001;
  localparam logic [15:0] TEMP_MIN = 16'h09E4;
  localparam logic [15:0] TEMP_MAX = 16'h0D04;
  localparam logic [15:0] PERMILLE_MAX = 16'h03E8;
  localparam logic [15:0] PERCENT_MAX = 16'h0064;
  localparam logic [15:0] PERMILLE_PER_PERCENT = 16'h000A;
  localparam logic [15:0] IMPEDANCE_MAX = 16'h00FF;
  localparam logic [15:0] BETA_RESET = 16'h0D34;
  localparam logic [15:0] TEMP_RESET = 16'h0BA6;
  localparam logic [15:0] ALARM_CHG_RESET = 16'h0008;
  localparam logic [15:0] ALARM_VOLT_RESET = 16'h0000;
  localparam logic [15:0] IMPEDANCE_RESET = 16'h0000;
  localparam logic [15:0] THERM_DELAY_RESET = 16'h001E;
  localparam logic [15:0] TSRC_RESET = 16'h0000;
  localparam logic [7:0] SLAVE_ADDR_WR = 8'h16;
  localparam logic [7:0] SLAVE_ADDR_RD = 8'h17;
  localparam logic [7:0] CRC_POLY = 8'h07;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing at a 4 ns clock.
  localparam int CLK_PERIOD_NS = 4;
  localparam int POR_OCV_DELAY_NS = 10_000_000;
  localparam int POR_OCV_CYCLES = POR_OCV_DELAY_NS / CLK_PERIOD_NS;
  localparam int INIT_MAX_NS = 1_500_000;
  localparam int INIT_MAX_CYCLES = INIT_MAX_NS / CLK_PERIOD_NS;
  localparam int TEMP_PERIOD_NS = 1_000_000_000;
  localparam int TEMP_PERIOD_CYCLES = TEMP_PERIOD_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [1:0] {INIT_POR_WAIT, INIT_RUN, INIT_PRESENT_WAIT} fgr_init_st_t;
  typedef enum logic [1:0] {THERM_IDLE, THERM_SETTLE, THERM_SENSE} fgr_therm_st_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] data;
    logic [7:0] crc;
  } fgr_wr_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic [7:0] crc;
  } fgr_rd_rsp_t;

  typedef struct packed {
    logic [15:0] thermistor_beta;
    logic [15:0] cell_temperature;
    logic [15:0] pack_impedance_value;
    logic [15:0] thermistor_delay_value;
    logic profile;
  } fgr_cfg_t;

endpackage : fgr_pkg

// file: fgr_crc8.sv
`timescale 1ns/100ps
// CRC-8 with polynomial x^8+x^2+x+1, zero start, first byte in the top bits.
module fgr_crc8 #(
  parameter int NBYTES = 4
) (
  // Data
  input wire logic [8*NBYTES-1:0] data_in,
  // Result
  output logic [7:0] crc_out
);

  always_comb begin
    logic [7:0] c;
    c = 8'h00;
    for (int i = 8 * NBYTES - 1; i >= 0; i--) begin
      if (c[7] ^ data_in[i]) begin
        c = {c[6:0], 1'b0} ^ fgr_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc_out = c;
  end

endmodule : fgr_crc8

// file: fgr_regs.sv
`timescale 1ns/100ps
module fgr_regs #(
  parameter int POR_OCV_CYCLES = fgr_pkg::POR_OCV_CYCLES,
  parameter int INIT_MAX_CYCLES = fgr_pkg::INIT_MAX_CYCLES,
  parameter int TEMP_PERIOD_CYCLES = fgr_pkg::TEMP_PERIOD_CYCLES,
  // Arbitrary identification values.
  parameter logic [15:0] CHIP_VERSION = 16'h5A01,
  parameter logic [15:0] PROFILE_SET_ID = 16'h0C0D
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register word writes
  input wire logic wr_valid,
  input wire fgr_pkg::fgr_wr_req_t wr_req,
  output logic wr_ack,
  output logic wr_crc_ok,
  // Register word reads
  input wire logic rd_valid,
  input wire logic [7:0] rd_cmd,
  output logic rd_ack,
  output fgr_pkg::fgr_rd_rsp_t rd_rsp,
  // Measurements
  input wire logic volt_valid,
  input wire logic [15:0] volt_mv,
  input wire logic thermistor_sense_valid,
  input wire logic [15:0] thermistor_sense,
  output logic thermistor_supply,
  // Charge estimator
  input wire logic est_valid,
  input wire logic [15:0] est_permille,
  output logic ocv_init_valid,
  output logic [15:0] open_circuit_voltage,
  output logic full_init,
  output logic track_enable,
  output fgr_pkg::fgr_cfg_t cfg,
  // Alarm pin
  output logic alarm_out_n_o,
  output logic alarm_out_n_oe
);

  typedef struct packed {
    fgr_pkg::fgr_init_st_t init_st;
    logic [31:0] init_cnt;
    fgr_pkg::fgr_therm_st_t therm_st;
    logic [31:0] therm_cnt;
    logic [15:0] beta;
    logic [15:0] temp;
    logic [15:0] volt;
    logic [15:0] dir;
    logic [15:0] imp_adj;
    logic [15:0] tdly_adj;
    logic [15:0] perm;
    logic [15:0] profile;
    logic [15:0] alarm_chg;
    logic [15:0] alarm_volt;
    logic [15:0] pwr;
    logic [15:0] tsrc;
    logic [15:0] peak;
    logic reinit_pending;
    logic low_chg;
    logic low_volt;
    logic init_pulse;
    logic [15:0] init_volt;
    logic track;
    logic full_init;
    logic supply;
    logic alarm_oe;
    logic wr_ack;
    logic wr_ok;
    logic rd_ack;
    fgr_pkg::fgr_rd_rsp_t rd_rsp;
  } fgr_state_t;

  fgr_state_t s_reg;
  fgr_state_t s_next;
  logic [7:0] wr_crc_calc;
  logic [7:0] rd_crc_calc;
  logic [15:0] rd_word;
  logic [15:0] percent;
  logic wr_good;
  logic operational;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame checks.
  fgr_crc8 #(.NBYTES(4)) u_wr_crc (
    .data_in({fgr_pkg::SLAVE_ADDR_WR, wr_req.cmd, wr_req.data[7:0], wr_req.data[15:8]}),
    .crc_out(wr_crc_calc)
  );

  fgr_crc8 #(.NBYTES(5)) u_rd_crc (
    .data_in({fgr_pkg::SLAVE_ADDR_WR, rd_cmd, fgr_pkg::SLAVE_ADDR_RD, rd_word[7:0],
              rd_word[15:8]}),
    .crc_out(rd_crc_calc)
  );

  assign wr_good = wr_valid && (wr_crc_calc == wr_req.crc);
  assign operational = (s_reg.pwr == fgr_pkg::PWR_OPERATIONAL);
  assign percent = s_reg.perm / fgr_pkg::PERMILLE_PER_PERCENT;

  always_comb begin
    case (rd_cmd)
      fgr_pkg::OFS_BETA: rd_word = s_reg.beta;
      fgr_pkg::OFS_TEMP: rd_word = s_reg.temp;
      fgr_pkg::OFS_VOLT: rd_word = s_reg.volt;
      fgr_pkg::OFS_DIR: rd_word = s_reg.dir;
      fgr_pkg::OFS_IMPEDANCE: rd_word = s_reg.imp_adj;
      fgr_pkg::OFS_THERM_DELAY: rd_word = s_reg.tdly_adj;
      fgr_pkg::OFS_PERCENT: rd_word = percent;
      fgr_pkg::OFS_PERMILLE: rd_word = s_reg.perm;
      fgr_pkg::OFS_VERSION: rd_word = CHIP_VERSION;
      fgr_pkg::OFS_PROFILE: rd_word = s_reg.profile;
      fgr_pkg::OFS_ALARM_CHG: rd_word = s_reg.alarm_chg;
      fgr_pkg::OFS_ALARM_VOLT: rd_word = s_reg.alarm_volt;
      fgr_pkg::OFS_PWR: rd_word = s_reg.pwr;
      fgr_pkg::OFS_TSRC: rd_word = s_reg.tsrc;
      fgr_pkg::OFS_PROFILE_ID: rd_word = PROFILE_SET_ID;
      default: rd_word = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    logic [15:0] est;
    est = (est_permille > fgr_pkg::PERMILLE_MAX) ? fgr_pkg::PERMILLE_MAX : est_permille;
    s_next = s_reg;
    s_next.init_pulse = 1'b0;
    s_next.full_init = 1'b0;
    s_next.wr_ack = wr_valid;
    s_next.wr_ok = wr_good;
    s_next.rd_ack = rd_valid;
    if (rd_valid) begin
      s_next.rd_rsp = '{data: rd_word, crc: rd_crc_calc};
    end
    // Sleep leaves the register port, the init timers and the alarm logic alive, but samples are dropped.
    if (operational && volt_valid) begin
      s_next.volt = volt_mv;
      if (s_reg.init_st == fgr_pkg::INIT_RUN && volt_mv > s_reg.peak) begin
        s_next.peak = volt_mv;
      end
    end
    // A held estimate is not advanced in sleep and resumes from where it stood.
    if (operational && est_valid) begin
      if (s_reg.reinit_pending || s_reg.dir == fgr_pkg::DIR_AUTO ||
          (s_reg.dir == fgr_pkg::DIR_CHARGE && est >= s_reg.perm) ||
          (s_reg.dir == fgr_pkg::DIR_DISCHARGE && est <= s_reg.perm)) begin
        s_next.perm = est;
      end
      s_next.reinit_pending = 1'b0;
    end
    case (s_reg.init_st)
      fgr_pkg::INIT_POR_WAIT: begin
        s_next.init_cnt = s_reg.init_cnt + 32'd1;
        if (s_reg.init_cnt == 32'(POR_OCV_CYCLES - 1)) begin
          s_next.init_pulse = 1'b1;
          s_next.init_volt = s_reg.volt;
          s_next.peak = s_reg.volt;
          s_next.reinit_pending = 1'b1;
          s_next.init_st = fgr_pkg::INIT_RUN;
        end
      end
      fgr_pkg::INIT_PRESENT_WAIT: begin
        s_next.init_cnt = s_reg.init_cnt + 32'd1;
        // A fresh sample is preferred; the deadline falls back to the held one.
        if (operational && volt_valid) begin
          s_next.init_pulse = 1'b1;
          s_next.init_volt = volt_mv;
          s_next.reinit_pending = 1'b1;
          s_next.init_st = fgr_pkg::INIT_RUN;
        end else if (s_reg.init_cnt == 32'(INIT_MAX_CYCLES - 1)) begin
          s_next.init_pulse = 1'b1;
          s_next.init_volt = s_reg.volt;
          s_next.reinit_pending = 1'b1;
          s_next.init_st = fgr_pkg::INIT_RUN;
        end
      end
      fgr_pkg::INIT_RUN: begin
        s_next.init_cnt = 32'd0;
      end
      default: s_next.init_st = fgr_pkg::INIT_POR_WAIT;
    endcase
    // Thermistor is powered only inside a measurement.
    if (!operational || s_reg.tsrc != fgr_pkg::TSRC_THERMISTOR) begin
      s_next.therm_st = fgr_pkg::THERM_IDLE;
      s_next.therm_cnt = 32'd0;
      s_next.supply = 1'b0;
    end else begin
      case (s_reg.therm_st)
        fgr_pkg::THERM_IDLE: begin
          s_next.therm_cnt = s_reg.therm_cnt + 32'd1;
          if (s_reg.therm_cnt >= 32'(TEMP_PERIOD_CYCLES - 1)) begin
            s_next.therm_cnt = 32'd0;
            s_next.supply = 1'b1;
            s_next.therm_st = fgr_pkg::THERM_SETTLE;
          end
        end
        fgr_pkg::THERM_SETTLE: begin
          s_next.therm_cnt = s_reg.therm_cnt + 32'd1;
          if (s_reg.therm_cnt >= {16'h0000, s_reg.tdly_adj}) begin
            s_next.therm_st = fgr_pkg::THERM_SENSE;
          end
        end
        fgr_pkg::THERM_SENSE: begin
          if (thermistor_sense_valid) begin
            if (thermistor_sense < fgr_pkg::TEMP_MIN) begin
              s_next.temp = fgr_pkg::TEMP_MIN;
            end else if (thermistor_sense > fgr_pkg::TEMP_MAX) begin
              s_next.temp = fgr_pkg::TEMP_MAX;
            end else begin
              s_next.temp = thermistor_sense;
            end
            s_next.supply = 1'b0;
            s_next.therm_cnt = 32'd0;
            s_next.therm_st = fgr_pkg::THERM_IDLE;
          end
        end
        default: s_next.therm_st = fgr_pkg::THERM_IDLE;
      endcase
    end
    // Host writes; anything unchecked, unknown or out of range changes nothing.
    if (wr_good) begin
      case (wr_req.cmd)
        fgr_pkg::OFS_INIT_PEAK: begin
          if (wr_req.data == fgr_pkg::INIT_KEY && s_reg.init_st == fgr_pkg::INIT_RUN) begin
            s_next.init_pulse = 1'b1;
            s_next.init_volt = s_reg.peak;
            s_next.reinit_pending = 1'b1;
          end
        end
        fgr_pkg::OFS_INIT_PRESENT: begin
          if (wr_req.data == fgr_pkg::INIT_KEY && s_reg.init_st == fgr_pkg::INIT_RUN) begin
            s_next.init_cnt = 32'd0;
            s_next.init_st = fgr_pkg::INIT_PRESENT_WAIT;
          end
        end
        fgr_pkg::OFS_BETA: s_next.beta = wr_req.data;
        fgr_pkg::OFS_TEMP: begin
          if (s_reg.tsrc == fgr_pkg::TSRC_HOST && wr_req.data >= fgr_pkg::TEMP_MIN &&
              wr_req.data <= fgr_pkg::TEMP_MAX) begin
            s_next.temp = wr_req.data;
          end
        end
        fgr_pkg::OFS_DIR: begin
          if (wr_req.data == fgr_pkg::DIR_AUTO || wr_req.data == fgr_pkg::DIR_CHARGE ||
              wr_req.data == fgr_pkg::DIR_DISCHARGE) begin
            s_next.dir = wr_req.data;
          end
        end
        fgr_pkg::OFS_IMPEDANCE: begin
          if (wr_req.data <= fgr_pkg::IMPEDANCE_MAX) begin
            s_next.imp_adj = wr_req.data;
          end
        end
        fgr_pkg::OFS_THERM_DELAY: s_next.tdly_adj = wr_req.data;
        fgr_pkg::OFS_PROFILE: begin
          if (wr_req.data <= fgr_pkg::PROFILE_MAX) begin
            s_next.profile = wr_req.data;
            s_next.full_init = 1'b1;
            s_next.init_cnt = 32'd0;
            s_next.init_st = fgr_pkg::INIT_POR_WAIT;
            s_next.init_pulse = 1'b0;
          end
        end
        fgr_pkg::OFS_ALARM_CHG: begin
          if (wr_req.data <= fgr_pkg::PERCENT_MAX) begin
            s_next.alarm_chg = wr_req.data;
          end
        end
        fgr_pkg::OFS_ALARM_VOLT: s_next.alarm_volt = wr_req.data;
        fgr_pkg::OFS_PWR: begin
          if (wr_req.data == fgr_pkg::PWR_OPERATIONAL || wr_req.data == fgr_pkg::PWR_SLEEP) begin
            s_next.pwr = wr_req.data;
          end
        end
        fgr_pkg::OFS_TSRC: begin
          if (wr_req.data == fgr_pkg::TSRC_HOST || wr_req.data == fgr_pkg::TSRC_THERMISTOR) begin
            s_next.tsrc = wr_req.data;
          end
        end
        default: ;
      endcase
    end
    // Equality keeps the previous alarm state, which gives a one-step hysteresis.
    if (s_reg.alarm_chg == 16'h0000 || percent > s_reg.alarm_chg) begin
      s_next.low_chg = 1'b0;
    end else if (percent < s_reg.alarm_chg) begin
      s_next.low_chg = 1'b1;
    end
    if (s_reg.alarm_volt == 16'h0000 || s_reg.volt > s_reg.alarm_volt) begin
      s_next.low_volt = 1'b0;
    end else if (s_reg.volt < s_reg.alarm_volt) begin
      s_next.low_volt = 1'b1;
    end
    s_next.alarm_oe = s_next.low_chg || s_next.low_volt;
    s_next.track = (s_next.pwr == fgr_pkg::PWR_OPERATIONAL);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.beta <= fgr_pkg::BETA_RESET;
      s_reg.temp <= fgr_pkg::TEMP_RESET;
      s_reg.dir <= fgr_pkg::DIR_AUTO;
      s_reg.imp_adj <= fgr_pkg::IMPEDANCE_RESET;
      s_reg.tdly_adj <= fgr_pkg::THERM_DELAY_RESET;
      s_reg.track <= 1'b1;
      s_reg.alarm_chg <= fgr_pkg::ALARM_CHG_RESET;
      s_reg.alarm_volt <= fgr_pkg::ALARM_VOLT_RESET;
      s_reg.pwr <= fgr_pkg::PWR_OPERATIONAL;
      s_reg.tsrc <= fgr_pkg::TSRC_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign wr_ack = s_reg.wr_ack;
  assign wr_crc_ok = s_reg.wr_ok;
  assign rd_ack = s_reg.rd_ack;
  assign rd_rsp = s_reg.rd_rsp;
  assign thermistor_supply = s_reg.supply;
  assign ocv_init_valid = s_reg.init_pulse;
  assign open_circuit_voltage = s_reg.init_volt;
  assign full_init = s_reg.full_init;
  assign track_enable = s_reg.track;
  assign cfg = '{thermistor_beta: s_reg.beta, cell_temperature: s_reg.temp,
                 pack_impedance_value: s_reg.imp_adj, thermistor_delay_value: s_reg.tdly_adj,
                 profile: s_reg.profile[0]};
  assign alarm_out_n_o = 1'b0;
  assign alarm_out_n_oe = s_reg.alarm_oe;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_present_cmd;
    wr_good && wr_req.cmd == fgr_pkg::OFS_INIT_PRESENT && wr_req.data == fgr_pkg::INIT_KEY &&
      s_reg.init_st == fgr_pkg::INIT_RUN;
  endsequence

  property p_por_sample;
    s_reg.init_st == fgr_pkg::INIT_POR_WAIT && s_reg.init_cnt == 32'(POR_OCV_CYCLES - 1) &&
      !wr_good |=> ocv_init_valid && open_circuit_voltage == $past(s_reg.volt);
  endproperty
  a_por_sample: assert property (p_por_sample) else $error("no voltage init at end of wait");

  property p_peak_init;
    wr_good && wr_req.cmd == fgr_pkg::OFS_INIT_PEAK && wr_req.data == fgr_pkg::INIT_KEY &&
      s_reg.init_st == fgr_pkg::INIT_RUN |=> ocv_init_valid &&
      open_circuit_voltage == $past(s_reg.peak);
  endproperty
  a_peak_init: assert property (p_peak_init) else $error("peak init missing");

  property p_present_start;
    s_present_cmd |=> s_reg.init_st == fgr_pkg::INIT_PRESENT_WAIT && s_reg.init_cnt == 32'd0;
  endproperty
  a_present_start: assert property (p_present_start) else $error("present init not armed");

  property p_present_bound;
    s_reg.init_st == fgr_pkg::INIT_PRESENT_WAIT |-> s_reg.init_cnt < 32'(INIT_MAX_CYCLES);
  endproperty
  a_present_bound: assert property (p_present_bound) else $error("present init overran");

  property p_temp_range;
    s_reg.temp >= fgr_pkg::TEMP_MIN && s_reg.temp <= fgr_pkg::TEMP_MAX;
  endproperty
  a_temp_range: assert property (p_temp_range) else $error("temperature out of range");

  property p_supply_only_measuring;
    thermistor_supply |-> s_reg.therm_st != fgr_pkg::THERM_IDLE &&
      $past(s_reg.tsrc) == fgr_pkg::TSRC_THERMISTOR;
  endproperty
  a_supply_only_measuring: assert property (p_supply_only_measuring) else $error("stray supply");

  property p_charge_clamp;
    s_reg.dir == fgr_pkg::DIR_CHARGE && !s_reg.reinit_pending |=> s_reg.perm >= $past(s_reg.perm);
  endproperty
  a_charge_clamp: assert property (p_charge_clamp) else $error("charge fell in charge mode");

  property p_discharge_clamp;
    s_reg.dir == fgr_pkg::DIR_DISCHARGE && !s_reg.reinit_pending |=>
      s_reg.perm <= $past(s_reg.perm);
  endproperty
  a_discharge_clamp: assert property (p_discharge_clamp) else $error("charge rose");

  property p_permille_max;
    s_reg.perm <= fgr_pkg::PERMILLE_MAX;
  endproperty
  a_permille_max: assert property (p_permille_max) else $error("permille above full");

  property p_sleep_hold;
    s_reg.pwr == fgr_pkg::PWR_SLEEP |=> $stable(s_reg.perm) && $stable(s_reg.volt);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("estimate moved in sleep");

  property p_profile_init;
    wr_good && wr_req.cmd == fgr_pkg::OFS_PROFILE && wr_req.data <= fgr_pkg::PROFILE_MAX |=>
      full_init && s_reg.init_st == fgr_pkg::INIT_POR_WAIT ##1 !full_init;
  endproperty
  a_profile_init: assert property (p_profile_init) else $error("no full init");

  property p_bad_crc;
    wr_valid && !wr_good && !volt_valid && !est_valid && !thermistor_sense_valid |=>
      $stable(cfg) && $stable(s_reg.dir) &&
      $stable(s_reg.pwr) && !wr_crc_ok && wr_ack;
  endproperty
  a_bad_crc: assert property (p_bad_crc) else $error("bad CRC write took effect");

  property p_alarm_low_charge;
    s_reg.alarm_chg != 16'h0000 && percent < s_reg.alarm_chg |=> alarm_out_n_oe;
  endproperty
  a_alarm_low_charge: assert property (p_alarm_low_charge) else $error("charge alarm lost");

  property p_alarm_release;
    (s_reg.alarm_chg == 16'h0000 || percent > s_reg.alarm_chg) &&
      (s_reg.alarm_volt == 16'h0000 || s_reg.volt > s_reg.alarm_volt) |=> !alarm_out_n_oe;
  endproperty
  a_alarm_release: assert property (p_alarm_release) else $error("alarm not released");

endmodule : fgr_regs

// file: fgr_host_model.sv
`timescale 1ns/100ps
// Host on the word port; it works out its own CRC so that the device is checked against it.
module fgr_host_model (
  // Clock
  input wire logic clock,
  // Requests
  output logic wr_valid,
  output fgr_pkg::fgr_wr_req_t wr_req,
  output logic rd_valid,
  output logic [7:0] rd_cmd,
  // Answers
  input wire logic wr_ack,
  input wire logic wr_crc_ok,
  input wire logic rd_ack,
  input wire fgr_pkg::fgr_rd_rsp_t rd_rsp
);
  function automatic logic [7:0] crc(input logic [39:0] b, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = n * 8 - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc
  initial begin
    wr_valid = 1'b0;
    rd_valid = 1'b0;
    wr_req = '0;
    rd_cmd = 8'h00;
  end
  task automatic wr(input logic [7:0] c, input logic [15:0] x, input logic bad, output logic ok);
    @(posedge clock);
    wr_valid <= 1'b1;
    wr_req <= {c, x, crc({8'h00, 8'h16, c, x[7:0], x[15:8]}, 4) ^ {7'h00, bad}};
    @(posedge clock);
    wr_valid <= 1'b0;
    #1;
    ok = wr_ack & wr_crc_ok;
  endtask : wr
  task automatic rd(input logic [7:0] c, output logic [15:0] x, output logic ok);
    @(posedge clock);
    rd_valid <= 1'b1;
    rd_cmd <= c;
    @(posedge clock);
    rd_valid <= 1'b0;
    #1;
    x = rd_rsp.data;
    ok = rd_ack & (rd_rsp.crc === crc({8'h16, c, 8'h17, x[7:0], x[15:8]}, 5));
  endtask : rd
endmodule : fgr_host_model

// file: fgr_regs_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module fgr_regs_tb_top;
  // Arbitrary identification values.
  localparam logic [15:0] VER = 16'h3C5A;
  localparam logic [15:0] PSID = 16'h7E11;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] vld = 3'b000;
  logic [15:0] val = 16'h0000;
  logic wr_valid, wr_ack, wr_crc_ok, rd_valid, rd_ack, init_p, full_init, track_en, supply, oe, ok;
  logic ao;
  logic [7:0] rd_cmd;
  logic [15:0] init_v, d, v, w, p, q, t;
  logic [3:0] ev;
  fgr_pkg::fgr_wr_req_t wr_req;
  fgr_pkg::fgr_rd_rsp_t rd_rsp;
  fgr_pkg::fgr_cfg_t cfg;
  integer seed = 32'hF041;
  int num_errors = 0;
  int n_compared = 0;
  logic [7:0] ofs [9] = '{8'h06, 8'h08, 8'h0A, 8'h13, 8'h14, 8'h15, 8'h16, 8'h11, 8'h1A};
  logic [15:0] rv [9] = '{16'h0D34, 16'h0BA6, 16'h0000, 16'h0008, 16'h0000, 16'h0001, 16'h0000,
    VER, PSID};
  // The run leaves direction in auto mode, as a careful host would.
  logic [15:0] dirs [3] = '{16'h0001, 16'hFFFF, 16'h0000};
  assign ev = {~supply, supply, full_init, init_p};
  initial begin
    forever #2 clock = ~clock;
  end
  fgr_regs #(.POR_OCV_CYCLES(20), .INIT_MAX_CYCLES(30), .TEMP_PERIOD_CYCLES(50),
    .CHIP_VERSION(VER), .PROFILE_SET_ID(PSID)) DUT (.clock, .rstn, .wr_valid, .wr_req, .wr_ack,
    .wr_crc_ok, .rd_valid, .rd_cmd, .rd_ack, .rd_rsp, .volt_valid(vld[0]), .volt_mv(val),
    .thermistor_sense_valid(vld[2]), .thermistor_sense(val), .thermistor_supply(supply),
    .est_valid(vld[1]), .est_permille(val), .ocv_init_valid(init_p),
    .open_circuit_voltage(init_v), .full_init, .track_enable(track_en), .cfg(cfg),
    .alarm_out_n_o(ao), .alarm_out_n_oe(oe));
  fgr_host_model host (.clock, .wr_valid, .wr_req, .rd_valid, .rd_cmd, .wr_ack, .wr_crc_ok,
    .rd_ack, .rd_rsp);
  function automatic logic [15:0] rnd(input int m);
    return 16'($unsigned($random(seed)) % m);
  endfunction : rnd
  function automatic logic [15:0] exp_dir(input logic [15:0] m, o, x);
    if (m == 16'h0001) return (x > o) ? x : o;
    if (m == 16'hFFFF) return (x < o) ? x : o;
    return x;
  endfunction : exp_dir
  task automatic close_out;
    $display("Errors %0d of %0d comparisons", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // Checks the present cycle first, so a pulse that is already showing is caught.
  task automatic wait_ev(input int k, input int n);
    for (int i = 0; i < n; i++) begin
      if (ev[k] === 1'b1) return;
      tick(1);
    end
    num_errors++;
    close_out();
  endtask : wait_ev
  task automatic send(input logic [2:0] m, input logic [15:0] x);
    @(posedge clock);
    vld <= m;
    val <= x;
    @(posedge clock);
    vld <= 3'b000;
    #1;
  endtask : send
  task automatic put(input logic [7:0] c, input logic [15:0] x);
    host.wr(c, x, 1'b0, ok);
    `CHK(ok, 1'b1)
  endtask : put
  task automatic chk_rd(input logic [7:0] c, input logic [15:0] e);
    host.rd(c, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, e)
  endtask : chk_rd
  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    v = 16'h0E00 + rnd(512);
    send(3'b001, v);
    wait_ev(0, 40);
    `CHK(init_v, v)
    for (int i = 0; i < 9; i++) chk_rd(ofs[i], rv[i]);
    chk_rd(8'h09, v);
    put(8'h11, 16'h1234);
    chk_rd(8'h11, VER);
    host.wr(8'h13, 16'h0020, 1'b1, ok);
    `CHK(ok, 1'b0)
    chk_rd(8'h13, 16'h0008);
    put(8'h0B, 16'h0036);
    `CHK(cfg.pack_impedance_value, 16'h0036)
    put(8'h0A, 16'h0002);
    chk_rd(8'h0A, 16'h0000);
    p = rnd(1001);
    send(3'b010, p);
    chk_rd(8'h0F, p);
    chk_rd(8'h0D, p / 16'h000A);
    for (int i = 0; i < 3; i++) begin
      put(8'h0A, dirs[i]);
      q = rnd(1001);
      send(3'b010, q);
      p = exp_dir(dirs[i], p, q);
      chk_rd(8'h0F, p);
    end
    send(3'b010, 16'h0032);
    tick(2);
    `CHK({oe, ao}, 2'b10)
    send(3'b010, 16'h005A);
    tick(2);
    `CHK(oe, 1'b0)
    put(8'h14, v + 16'h0001);
    tick(2);
    `CHK(oe, 1'b1)
    send(3'b001, v + 16'h0002);
    tick(2);
    `CHK(oe, 1'b0)
    put(8'h15, 16'h0002);
    tick(1);
    `CHK(track_en, 1'b0)
    send(3'b010, 16'h012C);
    chk_rd(8'h0F, 16'h005A);
    put(8'h15, 16'h0001);
    tick(1);
    `CHK(track_en, 1'b1)
    w = v - 16'h0001 - rnd(256);
    put(8'h07, 16'hAA55);
    send(3'b001, w);
    wait_ev(0, 5);
    `CHK(init_v, w)
    put(8'h04, 16'hAA55);
    wait_ev(0, 3);
    `CHK(init_v, v + 16'h0002)
    t = 16'h09E4 + rnd(801);
    put(8'h08, t);
    chk_rd(8'h08, t);
    put(8'h16, 16'h0001);
    `CHK(supply, 1'b0)
    wait_ev(2, 120);
    tick(40);
    t = 16'h09E4 + rnd(801);
    send(3'b100, t);
    wait_ev(3, 5);
    chk_rd(8'h08, t);
    put(8'h12, 16'h0001);
    wait_ev(1, 3);
    chk_rd(8'h12, 16'h0001);
    wait_ev(0, 40);
    close_out();
  end
endmodule : fgr_regs_tb_top
